// file: src/sscx_defines.svh
`ifndef SSCX_DEFINES_SVH
`define SSCX_DEFINES_SVH
// Register byte offsets
`define SSCX_OFS_TX_CLK_MODE   8'h00
`define SSCX_OFS_TX_FRAME_MODE 8'h04
`define SSCX_OFS_RX_HOLD       8'h08
`define SSCX_OFS_TX_HOLD       8'h0C
`define SSCX_OFS_RX_SYNC_HOLD  8'h10
`define SSCX_OFS_TX_SYNC_HOLD  8'h14
`define SSCX_OFS_STATUS        8'h18
`define SSCX_OFS_CTRL          8'h1C
// Writable bit masks, reserved bits read zero
`define SSCX_TCM_MASK          32'hFFFF0F00
`define SSCX_TFM_MASK          32'hF1FF0FBF
// Reset values
`define SSCX_TCM_RST           32'h00000000
`define SSCX_TFM_RST           32'h00000000
// Status bit positions
`define SSCX_ST_TX_READY       0
`define SSCX_ST_TX_EMPTY       1
`define SSCX_ST_TX_SYNC        10
`define SSCX_ST_TX_EN          16
// Start condition codes
`define SSCX_START_CONT        4'h0
`define SSCX_START_RX          4'h1
`define SSCX_START_LOW         4'h2
`define SSCX_START_HIGH        4'h3
`define SSCX_START_FALL        4'h4
`define SSCX_START_RISE        4'h5
`define SSCX_START_CHG         4'h6
`define SSCX_START_ANY         4'h7
// Frame pin shape codes
`define SSCX_FS_NONE           3'h0
`define SSCX_FS_NEG            3'h1
`define SSCX_FS_POS            3'h2
`define SSCX_FS_LOW            3'h3
`define SSCX_FS_HIGH           3'h4
`define SSCX_FS_TOGGLE         3'h5
// Word length limits for transfer size
`define SSCX_LEN_BYTE_MAX      5'h07
`define SSCX_LEN_HALF_MAX      5'h0F
`endif

// file: src/sscx_pkg.sv
package sscx_pkg;
    // Transmit clock mode layout
    typedef struct packed {
        logic [7:0] period;
        logic [7:0] delay;
        logic [3:0] rsv1;
        logic [3:0] start_sel;
        logic [7:0] rsv0;
    } sscx_tcm_t;
    // Transmit frame mode layout
    typedef struct packed {
        logic [3:0] len_ext;
        logic [2:0] rsv2;
        logic       edge_sel;
        logic       data_en;
        logic [2:0] shape;
        logic [3:0] sync_len;
        logic [3:0] rsv1;
        logic [3:0] words;
        logic       order;
        logic       rsv0;
        logic       idle_lvl;
        logic [4:0] bits;
    } sscx_tfm_t;
    // DMA transfer sizes
    typedef enum logic [1:0] {
        SSCX_DMA_BYTE,
        SSCX_DMA_HALF,
        SSCX_DMA_WORD
    } sscx_dsize_t;
    // Transmitter states
    typedef enum logic {
        SSCX_IDLE,
        SSCX_RUN
    } sscx_state_t;
endpackage : sscx_pkg

// file: src/sscx_tx_frame.sv
`timescale 1ns/1ps
`include "sscx_defines.svh"
// Notes on behaviour
// - nonzero start delay waits that many cycles
// - receiver-linked start also applies delay
// - period divider zero off, else 2x(P+1)
// - words carry length setting plus one bits
// - DMA size follows word length setting
// - idle data line at idle level
// - multi-drive pin enabled only when one
// - bit order selects LSB or MSB first
// - frame sends words setting plus one
// - sync length plus one, extended field
// - frame pin shape follows encoding
// - sync phase carries idle or sync word
// - edge select picks flag edge
// - receive word read right-justified
// - start condition is selectable
// - sync flag sticky until status read
module sscx_tx_frame (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    output logic             tx_data_pin_out,
    output logic             tx_data_pin_oe,
    input  wire logic        td_multi_drive,
    input  wire logic        tx_frame_pin_in,
    output logic             tx_frame_pin_out,
    output logic             tx_frame_pin_oe,
    input  wire logic        rx_start,
    input  wire logic [31:0] rx_word_in,
    input  wire logic [4:0]  rx_len,
    input  wire logic        rx_load,
    input  wire logic [15:0] rx_sync_in,
    input  wire logic        rx_sync_load,
    output logic             dma_req,
    output sscx_pkg::sscx_dsize_t dma_size
);
    sscx_pkg::sscx_tcm_t   cm_r;        // Clock mode
    sscx_pkg::sscx_tfm_t   fm_r;        // Frame mode
    sscx_pkg::sscx_state_t st_r;        // Transmit state
    logic [31:0] hold_r;                // Transmit holding word
    logic        hold_full_r;           // Holding word pending
    logic [31:0] cur_r;                 // Word being shifted
    logic [31:0] rx_r;                  // Receive holding word
    logic [15:0] rsh_r;                 // Receive sync word
    logic [15:0] tsh_r;                 // Transmit sync word
    logic        en_r;                  // Transmit enable
    logic        flag_r;                // Sticky sync flag
    logic [7:0]  dly_r;                 // Remaining start delay
    logic [8:0]  sidx_r;                // Sync phase bit index, spare bit ends longest pulse
    logic [4:0]  idx_r;                 // Data bit index
    logic [3:0]  wcnt_r;                // Words sent this frame
    logic [8:0]  per_r;                 // Period counter
    logic        tog_r;                 // Toggle shape level
    logic        tf_q_r;                // Previous frame pin input
    logic        lvl_q_r;               // Previous frame pin level
    logic [7:0]  aph_addr_r;            // Latched address phase
    logic        aph_wr_r;
    logic        aph_rd_r;
    logic        rd_wait_r;             // Read wait state done

    // Bus decode
    wire         bus_go  = hsel && htrans[1] && hready;
    wire         wr_go   = aph_wr_r;
    wire         rd_done = aph_rd_r && rd_wait_r;
    wire         wr_tcm  = wr_go && aph_addr_r == `SSCX_OFS_TX_CLK_MODE;
    wire         wr_tfm  = wr_go && aph_addr_r == `SSCX_OFS_TX_FRAME_MODE;
    wire         wr_thr  = wr_go && aph_addr_r == `SSCX_OFS_TX_HOLD;
    wire         wr_tsh  = wr_go && aph_addr_r == `SSCX_OFS_TX_SYNC_HOLD;
    wire         wr_ctl  = wr_go && aph_addr_r == `SSCX_OFS_CTRL;
    wire         rd_st   = rd_done && aph_addr_r == `SSCX_OFS_STATUS;
    wire [31:0]  st_word = ({31'h0, !hold_full_r} << `SSCX_ST_TX_READY)
                         | ({31'h0, !hold_full_r && st_r == sscx_pkg::SSCX_IDLE}
                            << `SSCX_ST_TX_EMPTY)
                         | ({31'h0, flag_r} << `SSCX_ST_TX_SYNC)
                         | ({31'h0, en_r} << `SSCX_ST_TX_EN);
    // Read mux, unmapped and write-only read zero
    wire [31:0]  rd_mux =
        (aph_addr_r == `SSCX_OFS_TX_CLK_MODE)   ? cm_r :
        (aph_addr_r == `SSCX_OFS_TX_FRAME_MODE) ? fm_r :
        (aph_addr_r == `SSCX_OFS_RX_HOLD)       ? rx_r :
        (aph_addr_r == `SSCX_OFS_RX_SYNC_HOLD)  ? {16'h0, rsh_r} :
        (aph_addr_r == `SSCX_OFS_TX_SYNC_HOLD)  ? {16'h0, tsh_r} :
        (aph_addr_r == `SSCX_OFS_STATUS)        ? st_word :
        (aph_addr_r == `SSCX_OFS_CTRL)          ? {31'h0, en_r} : 32'h0;

    // Reads take one wait state so hrdata comes from a flip-flop
    assign hreadyout = !(aph_rd_r && !rd_wait_r);
    assign hresp     = 1'b0;

    // Transfer size decode
    function automatic sscx_pkg::sscx_dsize_t size_of(input logic [4:0] len);
        size_of = (len <= `SSCX_LEN_BYTE_MAX) ? sscx_pkg::SSCX_DMA_BYTE :
                  (len <= `SSCX_LEN_HALF_MAX) ? sscx_pkg::SSCX_DMA_HALF :
                  sscx_pkg::SSCX_DMA_WORD;
    endfunction : size_of

    assign dma_size = size_of(fm_r.bits);
    assign dma_req  = en_r && !hold_full_r;

    // Frame timing terms
    wire         run      = st_r == sscx_pkg::SSCX_RUN;
    wire [7:0]   sync_top = {fm_r.len_ext, fm_r.sync_len};
    wire         sync_act = run && sidx_r <= {1'b0, sync_top};
    wire         data_on  = run && dly_r == 8'h00;
    wire         last_bit = data_on && idx_r == fm_r.bits;
    wire         last_wd  = last_bit && wcnt_r == fm_r.words;
    wire [8:0]   per_top  = {cm_r.period, 1'b1};
    wire         per_tick = en_r && cm_r.period != 8'h00 && per_r == per_top;

    // Start condition select
    wire         tf_fall  = tf_q_r && !tx_frame_pin_in;
    wire         tf_rise  = !tf_q_r && tx_frame_pin_in;
    wire         sel_hit  =
        (cm_r.start_sel == `SSCX_START_CONT) ? hold_full_r :
        (cm_r.start_sel == `SSCX_START_RX)   ? rx_start :
        (cm_r.start_sel == `SSCX_START_LOW)  ? !tx_frame_pin_in :
        (cm_r.start_sel == `SSCX_START_HIGH) ? tx_frame_pin_in :
        (cm_r.start_sel == `SSCX_START_FALL) ? tf_fall :
        (cm_r.start_sel == `SSCX_START_RISE) ? tf_rise :
        (cm_r.start_sel == `SSCX_START_CHG ||
         cm_r.start_sel == `SSCX_START_ANY)  ? (tf_fall || tf_rise) : 1'b0;
    wire         start_ev = en_r && !run && (sel_hit || per_tick);

    // Data line value
    wire [4:0]   bsel     = fm_r.order ? fm_r.bits - idx_r : idx_r;
    wire         data_bit = cur_r[bsel];
    wire         sync_bit = fm_r.data_en ? tsh_r[sidx_r[3:0]] : fm_r.idle_lvl;
    assign tx_data_pin_out = data_on ? data_bit :
                             sync_act ? sync_bit : fm_r.idle_lvl;
    assign tx_data_pin_oe  = td_multi_drive ? tx_data_pin_out : 1'b1;

    // Frame pin shape
    always_comb begin
        tx_frame_pin_oe  = 1'b1;
        tx_frame_pin_out = 1'b0;
        case (fm_r.shape)
            `SSCX_FS_NEG:    tx_frame_pin_out = !sync_act;
            `SSCX_FS_POS:    tx_frame_pin_out = sync_act;
            `SSCX_FS_LOW:    tx_frame_pin_out = !run;
            `SSCX_FS_HIGH:   tx_frame_pin_out = run;
            `SSCX_FS_TOGGLE: tx_frame_pin_out = tog_r;
            default:         tx_frame_pin_oe  = 1'b0;   // Input only or reserved
        endcase
    end

    // Flag edge on whatever level the frame pin carries
    wire         lvl      = tx_frame_pin_oe ? tx_frame_pin_out : tx_frame_pin_in;
    wire         sync_hit = fm_r.edge_sel ? (lvl_q_r && !lvl) : (!lvl_q_r && lvl);

    // Bus slave phases
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            aph_addr_r <= 8'h00;
            aph_wr_r   <= 1'b0;
            aph_rd_r   <= 1'b0;
            rd_wait_r  <= 1'b0;
            hrdata     <= 32'h0;
        end else begin
            if (hreadyout) begin
                aph_addr_r <= {haddr[7:2], 2'b00};
                aph_wr_r   <= bus_go && hwrite;
                aph_rd_r   <= bus_go && !hwrite;
            end
            rd_wait_r <= aph_rd_r && !rd_wait_r;
            if (aph_rd_r && !rd_wait_r) begin
                hrdata <= rd_mux;
            end
        end
    end

    // Software registers and receive capture
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cm_r  <= `SSCX_TCM_RST;
            fm_r  <= `SSCX_TFM_RST;
            tsh_r <= 16'h0;
            en_r  <= 1'b0;
            rx_r  <= 32'h0;
            rsh_r <= 16'h0;
        end else begin
            if (wr_tcm) cm_r <= hwdata & `SSCX_TCM_MASK;
            if (wr_tfm) fm_r <= hwdata & `SSCX_TFM_MASK;
            if (wr_tsh) tsh_r <= hwdata[15:0];
            if (wr_ctl) en_r <= hwdata[0];
            // Keep only the received bits, right-justified
            if (rx_load) rx_r <= rx_word_in & ~(32'hFFFFFFFE << rx_len);
            if (rx_sync_load) rsh_r <= rx_sync_in;
        end
    end

    // Holding register; a write in the same cycle as a take wins
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            hold_r      <= 32'h0;
            hold_full_r <= 1'b0;
        end else if (wr_thr) begin
            hold_r      <= hwdata;
            hold_full_r <= 1'b1;
        end else if (start_ev || (last_bit && !last_wd)) begin
            hold_full_r <= 1'b0;
        end
    end

    // Sync flag: set wins over the clearing status read
    always_ff @(posedge mclk) begin
        if (!rst_n) flag_r <= 1'b0;
        else flag_r <= sync_hit || (flag_r && !rd_st);
    end

    // Period counter free-runs while enabled and a divider is set
    always_ff @(posedge mclk) begin
        if (!rst_n || cm_r.period == 8'h00 || !en_r) per_r <= 9'h000;
        else per_r <= per_tick ? 9'h000 : per_r + 9'h001;
    end

    // Transmit sequencer; an empty holder resends the last word
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_r    <= sscx_pkg::SSCX_IDLE;
            cur_r   <= 32'h0;
            dly_r   <= 8'h00;
            sidx_r  <= 9'h000;
            idx_r   <= 5'h00;
            wcnt_r  <= 4'h0;
            tog_r   <= 1'b0;
            tf_q_r  <= 1'b0;
            lvl_q_r <= 1'b0;
        end else begin
            tf_q_r  <= tx_frame_pin_in;
            lvl_q_r <= lvl;
            case (st_r)
                sscx_pkg::SSCX_IDLE: begin
                    if (start_ev) begin
                        st_r   <= sscx_pkg::SSCX_RUN;
                        dly_r  <= cm_r.delay;
                        sidx_r <= 9'h000;
                        idx_r  <= 5'h00;
                        wcnt_r <= 4'h0;
                        tog_r  <= !tog_r;
                        if (hold_full_r) cur_r <= hold_r;
                    end
                end
                sscx_pkg::SSCX_RUN: begin
                    if (sync_act) sidx_r <= sidx_r + 9'h001;
                    if (!data_on) begin
                        dly_r <= dly_r - 8'h01;
                    end else if (last_wd) begin
                        st_r <= sscx_pkg::SSCX_IDLE;
                    end else if (last_bit) begin
                        idx_r  <= 5'h00;
                        wcnt_r <= wcnt_r + 4'h1;
                        if (hold_full_r) cur_r <= hold_r;
                    end else begin
                        idx_r <= idx_r + 5'h01;
                    end
                end
                default: st_r <= sscx_pkg::SSCX_IDLE;
            endcase
        end
    end

    // Checks
    sequence s_start_dly;
        start_ev && cm_r.delay != 8'h00;
    endsequence
    property p_dly;
        @(posedge mclk) disable iff (!rst_n) s_start_dly |=> !data_on;
    endproperty
    a_dly: assert property (p_dly) else $error("data before start delay");
    property p_nodly;
        @(posedge mclk) disable iff (!rst_n)
            start_ev && cm_r.delay == 8'h00 |=> data_on && idx_r == 5'h00;
    endproperty
    a_nodly: assert property (p_nodly) else $error("zero delay not immediate");
    property p_per;
        @(posedge mclk) disable iff (!rst_n)
            per_tick ##1 (cm_r.period != 8'h00 && en_r)
            |-> per_r == 9'h000 ##1 per_r == 9'h001;
    endproperty
    a_per: assert property (p_per) else $error("period counter wrong");
    property p_noper;
        @(posedge mclk) disable iff (!rst_n)
            cm_r.period == 8'h00 && !run && !sel_hit |=> !run;
    endproperty
    a_noper: assert property (p_noper) else $error("period tick with zero divider");
    property p_idle;
        @(posedge mclk) disable iff (!rst_n) !run |-> tx_data_pin_out == fm_r.idle_lvl;
    endproperty
    a_idle: assert property (p_idle) else $error("idle level wrong");
    property p_md;
        @(posedge mclk) disable iff (!rst_n)
            td_multi_drive && tx_data_pin_oe |-> tx_data_pin_out;
    endproperty
    a_md: assert property (p_md) else $error("multi-drive enabled at zero");
    property p_msb;
        @(posedge mclk) disable iff (!rst_n) data_on && fm_r.order && idx_r == 5'h00
            |-> tx_data_pin_out == cur_r[fm_r.bits];
    endproperty
    a_msb: assert property (p_msb) else $error("first bit not msb");
    property p_end;
        @(posedge mclk) disable iff (!rst_n) last_wd |=> !run;
    endproperty
    a_end: assert property (p_end) else $error("frame did not end");
    property p_pos;
        @(posedge mclk) disable iff (!rst_n) start_ev && fm_r.shape == `SSCX_FS_POS
            |=> tx_frame_pin_out && tx_frame_pin_oe;
    endproperty
    a_pos: assert property (p_pos) else $error("positive pulse missing");
    property p_flag;
        @(posedge mclk) disable iff (!rst_n) sync_hit |=> flag_r;
    endproperty
    a_flag: assert property (p_flag) else $error("sync flag lost");
endmodule : sscx_tx_frame

// file: tb/sscx_partner.sv
`timescale 1ns/1ps
// Far-side serial device: records the data line from each frame rise
module sscx_partner (
    input  wire logic  mclk,
    input  wire logic  rst_n,
    input  wire logic  data_line,
    input  wire logic  frame_line,
    output logic [63:0] cap,
    output logic [7:0]  per,
    output logic [7:0]  hi,
    output logic [7:0]  nrise
);
    logic       fl_q; // Frame level one cycle back
    logic [7:0] cnt;  // Cycles since the last frame rise
    logic [6:0] idx;  // Next capture slot
    // One bit per clock, slot 0 is the first frame cycle
    always @(posedge mclk) begin
        fl_q <= frame_line;
        if (!rst_n) begin
            cnt   <= 8'h00;
            idx   <= 7'h40;
            nrise <= 8'h00;
            hi    <= 8'h00;
            per   <= 8'h00;
        end else if (frame_line && !fl_q) begin
            per    <= cnt + 8'h01;
            cnt    <= 8'h00;
            hi     <= 8'h01;
            nrise  <= nrise + 8'h01;
            cap    <= {63'h0, data_line};
            idx    <= 7'h01;
        end else begin
            cnt <= cnt + 8'h01;
            // Pulse width counted while the line stays high
            if (frame_line && fl_q) hi <= hi + 8'h01;
            if (idx < 7'h40) begin
                cap[idx[5:0]] <= data_line;
                idx           <= idx + 7'h01;
            end
        end
    end
endmodule : sscx_partner

// file: tb/sscx_tx_frame_tb.sv
`timescale 1ns/1ps
`include "sscx_defines.svh"
module sscx_tx_frame_tb;
    logic        mclk = 0, rst_n = 0, hwrite = 0, td_md = 0, frm_lvl = 0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, rd_s, rx_word_in = 32'h0, d;
    logic        rx_start = 0, rx_load = 0, rx_sync_load = 0;
    logic [4:0]  rx_len = 5'h00;
    logic [15:0] rx_sync_in = 16'h0;
    logic        hreadyout, td_out, td_oe, fr_out, fr_oe, dma_req;
    logic [31:0] hrdata;
    logic [63:0] cap;
    logic [7:0]  per, hi, nrise, n0;
    sscx_pkg::sscx_dsize_t dma_size;
    int          fail_count = 0, tests_run = 0;
    // Multi-drive only ever drives ones, so a released line must fall to zero
    wire data_line  = td_oe ? td_out : 1'b0; // Pull-down when released
    int  lens [4] = '{7, 8, 15, 16}; // Word length settings, zero never used
    wire frame_line = fr_oe ? fr_out : frm_lvl;
    always #10 mclk = ~mclk;
    sscx_tx_frame sscx_tx_frame_i (.mclk(mclk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(),
        .tx_data_pin_out(td_out), .tx_data_pin_oe(td_oe), .td_multi_drive(td_md),
        .tx_frame_pin_in(frame_line), .tx_frame_pin_out(fr_out), .tx_frame_pin_oe(fr_oe),
        .rx_start(rx_start), .rx_word_in(rx_word_in), .rx_len(rx_len), .rx_load(rx_load),
        .rx_sync_in(rx_sync_in), .rx_sync_load(rx_sync_load), .dma_req(dma_req),
        .dma_size(dma_size));
    sscx_partner sscx_partner_i (.mclk(mclk), .rst_n(rst_n), .data_line(data_line),
        .frame_line(frame_line), .cap(cap), .per(per), .hi(hi), .nrise(nrise));
    // Ready is looked at just before the edge that samples it
    task automatic wait_rdy();
        bit ok;
        ok = 0;
        while (!ok) begin
            @(negedge mclk);
            ok   = (hreadyout === 1'b1);
            rd_s = hrdata;
            @(posedge mclk);
        end
    endtask : wait_rdy
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= 1'b1;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= v;
        wait_rdy();
        @(negedge mclk); // Let the write land before callers look at outputs
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= 1'b0;
        wait_rdy();
        htrans <= 2'b00;
        wait_rdy();
        v = rd_s;
    endtask : rd
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Captured word from a slot, in either bit order
    task automatic chk_word(input int b, input logic [31:0] w, input int n, input bit msb);
        for (int i = 0; i < n; i++) chk("data bit", cap[b+i], msb ? w[n-1-i] : w[i]);
    endtask : chk_word
    task automatic end_of_test();
        $display("checks %0d errors %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    // Watchdog well beyond the planned few hundred cycles
    initial begin
        #400us;
        fail_count++;
        end_of_test();
    end
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        // Reset values, write-only and unmapped places
        rd(8'h04, d); chk("frame mode rst", d, `SSCX_TFM_RST);
        rd(8'h0C, d); chk("tx hold read", d, 32'h0);
        wr(8'h40, 32'hFFFFFFFF);
        rd(8'h40, d); chk("unmapped", d, 32'h0);
        wr(8'h04, 32'hFFFFFFFF);
        rd(8'h04, d); chk("frame mode mask", d, `SSCX_TFM_MASK);
        // Transfer size per length setting, never zero
        for (int k = 0; k < 4; k++) begin
            wr(8'h04, lens[k]);
            chk("dma size", dma_size, k == 0 ? 0 : (k < 3 ? 1 : 2));
        end
        // Frame pin shapes while idle
        for (int s = 0; s < 6; s++) begin
            wr(8'h04, 32'h00000007 | (s << 20));
            chk("frame oe", fr_oe, s != 0);
            if (s == 1) chk("neg idle", fr_out, 1'b1);
            if (s == 2) chk("pos idle", fr_out, 1'b0);
        end
        // Tag of two bits, delay 3 covers it
        wr(8'h00, 32'h00030000);
        wr(8'h14, 32'h0000A5A5);
        wr(8'h04, 32'h00A10107);
        wr(8'h1C, 32'h1);
        chk("dma req empty", dma_req, 1'b1);
        wr(8'h0C, 32'h000000C3); // Right-justified byte
        repeat (30) @(posedge mclk);
        chk("pulse len", hi, 8'h02);
        chk("tag bits", cap[1:0], 2'b01);
        chk("gap idle", cap[2], 1'b0);
        chk_word(3, 32'hC3, 8, 0);
        chk_word(11, 32'hC3, 8, 0);
        chk("after idle", cap[19], 1'b0);
        rd(8'h18, d); chk("sync flag set", d[10], 1'b1);
        rd(8'h18, d); chk("sync flag clr", d[10], 1'b0);
        // Sixteen bits MSB first, idle high, zero delay
        td_md <= 1'b1;
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h002000AF);
        chk("idle high", td_out, 1'b1);
        wr(8'h0C, 32'h0000B00D);
        repeat (20) begin
            @(negedge mclk);
            chk("multi drive oe", td_oe, td_out);
        end
        chk_word(0, 32'hB00D, 16, 1);
        chk("tail idle", cap[16], 1'b1);
        td_md <= 1'b0;
        // Receiver-linked start, delay 2
        wr(8'h00, 32'h00020100);
        wr(8'h04, 32'h00200003);
        wr(8'h0C, 32'h00000009);
        @(posedge mclk);
        rx_start <= 1'b1;
        @(posedge mclk);
        rx_start <= 1'b0;
        repeat (12) @(posedge mclk);
        chk("delay slots", cap[1:0], 2'b00);
        chk_word(2, 32'h9, 4, 0);
        // Period divider 2 gives a frame every 6 clocks
        wr(8'h04, 32'h00200001);
        wr(8'h00, 32'h02000000);
        repeat (40) @(posedge mclk);
        chk("period", per, 8'h06);
        wr(8'h00, 32'h0);
        repeat (4) @(posedge mclk);
        n0 = nrise;
        repeat (30) @(posedge mclk);
        chk("no period", nrise, n0);
        // Rising edge on the input-only frame pin starts, flag on falling edge
        wr(8'h00, 32'h00000500);
        wr(8'h04, 32'h01000003);
        wr(8'h0C, 32'h00000006);
        rd(8'h18, d); // Clear the sticky flag
        @(posedge mclk);
        frm_lvl <= 1'b1;
        repeat (8) @(posedge mclk);
        chk_word(1, 32'h6, 4, 0);
        rd(8'h18, d); chk("rise no flag", d[10], 1'b0);
        frm_lvl <= 1'b0;
        repeat (2) @(posedge mclk);
        rd(8'h18, d); chk("fall flag", d[10], 1'b1);
        // Receive holding registers read right-justified
        rx_word_in   <= 32'hFFFFFFFF;
        rx_len       <= 5'h07;
        rx_sync_in   <= 16'h1234;
        rx_load      <= 1'b1;
        rx_sync_load <= 1'b1;
        @(posedge mclk);
        rx_load      <= 1'b0;
        rx_sync_load <= 1'b0;
        rd(8'h08, d); chk("rx word", d, 32'h000000FF);
        rd(8'h10, d); chk("rx sync", d, 32'h00001234);
        end_of_test();
    end
endmodule : sscx_tx_frame_tb
